// >>> design/flex_clock_defines.svh
/*
  Register indices, field positions and reset values of the flexible
  master-clock configuration block.
  Assumes a byte address of four times the index on the register bus.
*/
`ifndef FLEX_CLOCK_DEFINES_SVH
`define FLEX_CLOCK_DEFINES_SVH

// Register indices (byte address = 4 x index)
`define IDX_E1_CORR_LO     10'h091
`define IDX_E1_CORR_HI     10'h092
`define IDX_T1_CORR_LO     10'h094
`define IDX_T1_CORR_HI     10'h095
`define IDX_PLL_IN_DIV     10'h096
`define IDX_PLL_FB_DIV     10'h097
`define IDX_E1_RX_DIV      10'h098
`define IDX_T1_RX_DIV      10'h099
`define IDX_MISC_CTL       10'h0A0

// Field positions
`define CORR_HI_NIB_MSB    3
`define E1HI_PHS_CTL_A     7
`define E1HI_PHS_DIR       6
`define E1HI_PHS_SW        5
`define E1HI_FLEX_EN       4
`define T1HI_DVM_MSB       7
`define T1HI_DVM_LSB       5
`define PLLM_RANGE_LOW     7
`define PLLM_MSB           4
`define PLLN_MSB           5
`define RXDIV_FIXED_ONE    7
`define RXDIV_SIX_MSB      6
`define RXDIV_SIX_LSB      4
`define RXDIV_INT_MSB      3
`define MISC_HOST_SEL_MSB  1
`define MISC_PORT_PHS_X    2
`define MISC_PORT_PHS_R    3

// Reset values
`define RST_BYTE           8'h00
`define RST_RXDIV          7'h00
`define RST_HOST_SEL       2'h0

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> design/flex_clock_pkg.sv
/*
  Types of the flexible master-clock configuration block.
  Assumes the constants of flex_clock_defines.svh for field layout.
*/
package flex_clock_pkg;

  // Configuration presented to the clock datapath
  typedef struct packed {
    logic        flex_en;
    logic [1:0]  host_interface_select;
    logic        phase_decoder_ctl_a;
    logic        phase_decoder_direction;
    logic        phase_decoder_switch;
    logic        port_phase_ctl_x;
    logic        port_phase_ctl_r;
    logic [4:0]  pll_input_factor;
    logic [5:0]  pll_feedback_factor;
    logic [2:0]  e1_rx_sixths;
    logic [3:0]  e1_rx_integer;
    logic [2:0]  t1_rx_sixths;
    logic [3:0]  t1_rx_integer;
    logic [11:0] e1_freq_correction;
    logic [11:0] t1_freq_correction;
  } clk_cfg_t;

  // Receiver divider field pair
  typedef struct packed {
    logic [2:0] sixths;
    logic [3:0] integ;
  } rx_div_t;

endpackage : flex_clock_pkg

// >>> design/flexible_master_clock_pll_config.sv
/*
  Flexible master-clock configuration registers with an AXI4-Lite slave.
  Holds PLL divider factors, receiver dividers and correction values and
  issues a PLL reset pulse on PLL divider writes in flexible async mode.
  Assumes one clock, a synchronous active-low reset and a master that
  keeps at most one write and one read under way.
*/
// Behaviour
// - T1 correction: 12-bit, low byte plus nibble
// - Legacy T1 divider mode stored, no effect
// - Legacy range-low flag stored, no effect
// - PLL divider write resets PLL in flexible async
// - Input divider factor in bits 4:0
// - Feedback divider factor in low bits
// - PLL output is mclk times 4(N+1)/(M+1)
// - E1 correction by rounding formula, 12288
// - T1 correction by same rounding formula
// - E1 receiver divider: one, sixths, integer
// - T1 receiver divider with same layout
// - Fixed mode ignores dividers and corrections
// - E1 correction: nibble plus companion byte
`timescale 1ns/100ps
`include "flex_clock_defines.svh"

module flexible_master_clock_pll_config #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output      logic                      s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output      logic                      s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]                s_axi_bresp,
  output      logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output      logic                      s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0]               s_axi_rdata,
  output      logic [1:0]                s_axi_rresp,
  output      logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Clock datapath side
  output      flex_clock_pkg::clk_cfg_t  clk_cfg,
  output      logic                      pll_reset
);

  // Bus state
  logic                 aw_hold_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic                 w_hold_q;
  logic [7:0]           wbyte_q;
  logic                 wlane_q;
  logic                 awready_q;
  logic                 wready_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 arready_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;

  // Register contents
  logic [7:0]           e1_lo_q;
  logic [3:0]           e1_hi_q;
  logic                 phs_ctl_a_q;
  logic                 phs_dir_q;
  logic                 phs_sw_q;
  logic                 flex_en_q;
  logic [7:0]           t1_lo_q;
  logic [3:0]           t1_hi_q;
  logic [2:0]           dvm_q;
  logic                 range_low_q;
  logic [4:0]           pll_m_q;
  logic [5:0]           pll_n_q;
  flex_clock_pkg::rx_div_t e1_rx_q;
  flex_clock_pkg::rx_div_t t1_rx_q;
  logic [1:0]           host_sel_q;
  logic                 port_phs_x_q;
  logic                 port_phs_r_q;
  logic [11:0]          e1_corr_q;
  logic [11:0]          t1_corr_q;
  flex_clock_pkg::clk_cfg_t cfg_q;
  logic                 pll_reset_q;

  // Decode
  logic                 aw_fire;
  logic                 w_fire;
  logic                 ar_fire;
  logic                 wr_do;
  logic                 wr_en;
  logic [ADDR_W-3:0]    wr_idx;
  logic [ADDR_W-3:0]    rd_idx;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [7:0]           rd_byte;

  assign aw_fire = s_axi_awvalid && awready_q;
  assign w_fire  = s_axi_wvalid && wready_q;
  assign ar_fire = s_axi_arvalid && arready_q;
  assign wr_do   = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx  = awaddr_q[ADDR_W-1:2];
  assign rd_idx  = s_axi_araddr[ADDR_W-1:2];
  assign wr_en   = wr_do && wlane_q;

  function automatic logic is_mapped(input logic [ADDR_W-3:0] idx);
    case (idx)
      (ADDR_W-2)'(`IDX_E1_CORR_LO), (ADDR_W-2)'(`IDX_E1_CORR_HI),
      (ADDR_W-2)'(`IDX_T1_CORR_LO), (ADDR_W-2)'(`IDX_T1_CORR_HI),
      (ADDR_W-2)'(`IDX_PLL_IN_DIV), (ADDR_W-2)'(`IDX_PLL_FB_DIV),
      (ADDR_W-2)'(`IDX_E1_RX_DIV),  (ADDR_W-2)'(`IDX_T1_RX_DIV),
      (ADDR_W-2)'(`IDX_MISC_CTL):   is_mapped = 1'b1;
      default:                      is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign wr_hit = is_mapped(wr_idx);
  assign rd_hit = is_mapped(rd_idx);

  // Write address capture; held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      awready_q <= 1'b1;
    end else if (aw_fire) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
      awready_q <= 1'b0;
    end else if (wr_do) begin
      aw_hold_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  // Write data capture; only the low byte lane carries a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wbyte_q  <= `RST_BYTE;
      wlane_q  <= 1'b0;
      wready_q <= 1'b1;
    end else if (w_fire) begin
      w_hold_q <= 1'b1;
      wbyte_q  <= s_axi_wdata[7:0];
      wlane_q  <= s_axi_wstrb[0];
      wready_q <= 1'b0;
    end else if (wr_do) begin
      w_hold_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Correction values and mode flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e1_lo_q     <= `RST_BYTE;
      e1_hi_q     <= '0;
      phs_ctl_a_q <= 1'b0;
      phs_dir_q   <= 1'b0;
      phs_sw_q    <= 1'b0;
      flex_en_q   <= 1'b0;
      t1_lo_q     <= `RST_BYTE;
      t1_hi_q     <= '0;
      dvm_q       <= '0;
    end else if (wr_en) begin
      unique case (wr_idx)
        (ADDR_W-2)'(`IDX_E1_CORR_LO): e1_lo_q <= wbyte_q;
        (ADDR_W-2)'(`IDX_E1_CORR_HI): begin
          e1_hi_q     <= wbyte_q[`CORR_HI_NIB_MSB:0];
          phs_ctl_a_q <= wbyte_q[`E1HI_PHS_CTL_A];
          phs_dir_q   <= wbyte_q[`E1HI_PHS_DIR];
          phs_sw_q    <= wbyte_q[`E1HI_PHS_SW];
          flex_en_q   <= wbyte_q[`E1HI_FLEX_EN];
        end
        (ADDR_W-2)'(`IDX_T1_CORR_LO): t1_lo_q <= wbyte_q;
        (ADDR_W-2)'(`IDX_T1_CORR_HI): begin
          t1_hi_q <= wbyte_q[`CORR_HI_NIB_MSB:0];
          dvm_q   <= wbyte_q[`T1HI_DVM_MSB:`T1HI_DVM_LSB];
        end
        default: ;
      endcase
    end
  end

  // PLL and receiver divider factors, host mode bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_low_q  <= 1'b0;
      pll_m_q      <= '0;
      pll_n_q      <= '0;
      e1_rx_q      <= `RST_RXDIV;
      t1_rx_q      <= `RST_RXDIV;
      host_sel_q   <= `RST_HOST_SEL;
      port_phs_x_q <= 1'b0;
      port_phs_r_q <= 1'b0;
    end else if (wr_en) begin
      unique case (wr_idx)
        (ADDR_W-2)'(`IDX_PLL_IN_DIV): begin
          range_low_q <= wbyte_q[`PLLM_RANGE_LOW];
          pll_m_q     <= wbyte_q[`PLLM_MSB:0];
        end
        (ADDR_W-2)'(`IDX_PLL_FB_DIV): pll_n_q <= wbyte_q[`PLLN_MSB:0];
        (ADDR_W-2)'(`IDX_E1_RX_DIV):
          e1_rx_q <= wbyte_q[`RXDIV_SIX_MSB:0];
        (ADDR_W-2)'(`IDX_T1_RX_DIV):
          t1_rx_q <= wbyte_q[`RXDIV_SIX_MSB:0];
        (ADDR_W-2)'(`IDX_MISC_CTL): begin
          host_sel_q   <= wbyte_q[`MISC_HOST_SEL_MSB:0];
          port_phs_x_q <= wbyte_q[`MISC_PORT_PHS_X];
          port_phs_r_q <= wbyte_q[`MISC_PORT_PHS_R];
        end
        default: ;
      endcase
    end
  end

  // Committed corrections: the high byte write takes the staged low
  // byte along, so the datapath never sees half of an update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e1_corr_q <= '0;
      t1_corr_q <= '0;
    end else if (wr_en) begin
      if (wr_idx == (ADDR_W-2)'(`IDX_E1_CORR_HI)) begin
        e1_corr_q <= {wbyte_q[`CORR_HI_NIB_MSB:0], e1_lo_q};
      end
      if (wr_idx == (ADDR_W-2)'(`IDX_T1_CORR_HI)) begin
        t1_corr_q <= {wbyte_q[`CORR_HI_NIB_MSB:0], t1_lo_q};
      end
    end
  end

  // Mode decided before the write lands; bit 1 of the select low means
  // the asynchronous host interface.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_reset_q <= 1'b0;
    end else begin
      pll_reset_q <= wr_en && flex_en_q && !host_sel_q[1] &&
                     (wr_idx == (ADDR_W-2)'(`IDX_PLL_IN_DIV) ||
                      wr_idx == (ADDR_W-2)'(`IDX_PLL_FB_DIV));
    end
  end

  // Datapath view; the PLL forms mclk x 4(N+1)/(M+1) from these factors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q.flex_en                 <= flex_en_q;
      cfg_q.host_interface_select   <= host_sel_q;
      cfg_q.phase_decoder_ctl_a     <= phs_ctl_a_q;
      cfg_q.phase_decoder_direction <= phs_dir_q;
      cfg_q.phase_decoder_switch    <= phs_sw_q;
      cfg_q.port_phase_ctl_x        <= port_phs_x_q;
      cfg_q.port_phase_ctl_r        <= port_phs_r_q;
      cfg_q.pll_input_factor    <= flex_en_q ? pll_m_q : '0;
      cfg_q.pll_feedback_factor <= flex_en_q ? pll_n_q : '0;
      cfg_q.e1_rx_sixths        <= flex_en_q ? e1_rx_q.sixths : '0;
      cfg_q.e1_rx_integer       <= flex_en_q ? e1_rx_q.integ : '0;
      cfg_q.t1_rx_sixths        <= flex_en_q ? t1_rx_q.sixths : '0;
      cfg_q.t1_rx_integer       <= flex_en_q ? t1_rx_q.integ : '0;
      cfg_q.e1_freq_correction  <= flex_en_q ? e1_corr_q : '0;
      cfg_q.t1_freq_correction  <= flex_en_q ? t1_corr_q : '0;
    end
  end

  // Read mux; low bytes read back as written, not as committed
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      (ADDR_W-2)'(`IDX_E1_CORR_LO): rd_byte = e1_lo_q;
      (ADDR_W-2)'(`IDX_E1_CORR_HI):
        rd_byte = {phs_ctl_a_q, phs_dir_q, phs_sw_q, flex_en_q, e1_hi_q};
      (ADDR_W-2)'(`IDX_T1_CORR_LO): rd_byte = t1_lo_q;
      (ADDR_W-2)'(`IDX_T1_CORR_HI): rd_byte = {dvm_q, 1'b0, t1_hi_q};
      (ADDR_W-2)'(`IDX_PLL_IN_DIV): rd_byte = {range_low_q, 2'h0, pll_m_q};
      (ADDR_W-2)'(`IDX_PLL_FB_DIV): rd_byte = {2'h0, pll_n_q};
      (ADDR_W-2)'(`IDX_E1_RX_DIV):  rd_byte = {1'b1, e1_rx_q};
      (ADDR_W-2)'(`IDX_T1_RX_DIV):  rd_byte = {1'b1, t1_rx_q};
      (ADDR_W-2)'(`IDX_MISC_CTL):
        rd_byte = {4'h0, port_phs_r_q, port_phs_x_q, host_sel_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign clk_cfg       = cfg_q;
  assign pll_reset     = pll_reset_q;

endmodule : flexible_master_clock_pll_config

// >>> sim/flex_clock_properties.sv
/* Checker of bus answers, PLL reset pulse and configuration timing.
   Assumes it is bound to the configuration block's top-level ports. */
`timescale 1ns/100ps
`include "flex_clock_defines.svh"
module flex_clock_properties (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Write handshakes
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  // Read handshakes
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  // Datapath side
  input wire flex_clock_pkg::clk_cfg_t clk_cfg,
  input wire logic                     pll_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_after;
    (!s_axi_bvalid && !s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endsequence

  a_write_answer:
    assert property (s_both_taken |=> s_resp_after)
    else $error("write response not two cycles after take");
  a_resp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=>
                     s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  a_ready_back:
    assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write readies not restored after response");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=>
                     s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  a_read_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
                     $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before acceptance");
  a_slverr_zero:
    assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |->
                     s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");
  a_pll_one_cycle:
    assert property (pll_reset |=> !pll_reset)
    else $error("PLL reset pulse longer than one cycle");
  a_pll_with_resp:
    assert property (pll_reset |-> $rose(s_axi_bvalid) &&
                     s_axi_bresp == `RESP_OKAY)
    else $error("PLL reset not aligned with write landing");
  a_cfg_after_write:
    assert property (!$stable(clk_cfg) |->
                     $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("configuration changed outside write commit");
  a_fixed_zero:
    assert property (!clk_cfg.flex_en |-> clk_cfg.pll_input_factor == 5'h0
      && clk_cfg.pll_feedback_factor == 6'h0 && clk_cfg.e1_rx_integer == 4'h0
      && clk_cfg.e1_freq_correction == 12'h0
      && clk_cfg.t1_freq_correction == 12'h0)
    else $error("fixed mode exposes divider or correction");
endmodule : flex_clock_properties

// >>> sim/tb_top.sv
/* Self-checking bench of the flexible master-clock configuration block.
   Assumes an AXI4-Lite slave on one 50 MHz clock, synchronous low reset. */
`timescale 1ns/100ps
`include "flex_clock_defines.svh"
module tb_top;
  // Clock, reset and bus
  logic                     aclk;
  logic                     aresetn;
  logic [11:0]              s_axi_awaddr;
  logic                     s_axi_awvalid;
  logic                     s_axi_awready;
  logic [31:0]              s_axi_wdata;
  logic [3:0]               s_axi_wstrb;
  logic                     s_axi_wvalid;
  logic                     s_axi_wready;
  logic [1:0]               s_axi_bresp;
  logic                     s_axi_bvalid;
  logic                     s_axi_bready;
  logic [11:0]              s_axi_araddr;
  logic                     s_axi_arvalid;
  logic                     s_axi_arready;
  logic [31:0]              s_axi_rdata;
  logic [1:0]               s_axi_rresp;
  logic                     s_axi_rvalid;
  logic                     s_axi_rready;
  flex_clock_pkg::clk_cfg_t clk_cfg;
  logic                     pll_reset;
  // Bench state
  int                       fails;
  int                       tests_run;
  int                       pulses = 0;
  int                       p0;
  logic [1:0]               rsp;
  logic [31:0]              rd;
  logic [7:0]               v;
  logic [9:0]               idx_tab [9];

  flexible_master_clock_pll_config #(.ADDR_W(12))
    u_flexible_master_clock_pll_config (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_cfg, .pll_reset);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (pll_reset === 1'b1) pulses <= pulses + 1;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic strb, output logic [1:0] r);
    int n;
    int dly;
    dly = $urandom_range(0, 3);
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= {3'h0, strb};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (dly == 0);
    for (n = 1; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= dly) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
  endtask : wr

  task automatic rdreg(input logic [9:0] idx, output logic [31:0] d,
                       output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= ($urandom_range(0, 1) == 1);
    for (n = 1; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
  endtask : rdreg

  // Configuration lands one edge after the register
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_rd(input logic [9:0] idx,
                                        input logic [7:0] d);
    case (idx)
      `IDX_T1_CORR_HI: exp_rd = d & 8'hEF;
      `IDX_PLL_IN_DIV: exp_rd = d & 8'h9F;
      `IDX_PLL_FB_DIV: exp_rd = d & 8'h3F;
      `IDX_E1_RX_DIV, `IDX_T1_RX_DIV: exp_rd = d | 8'h80;
      `IDX_MISC_CTL: exp_rd = d & 8'h0F;
      default: exp_rd = d;
    endcase
  endfunction : exp_rd

  initial begin
    idx_tab = '{`IDX_E1_CORR_LO, `IDX_E1_CORR_HI, `IDX_T1_CORR_LO,
                `IDX_T1_CORR_HI, `IDX_PLL_IN_DIV, `IDX_PLL_FB_DIV,
                `IDX_E1_RX_DIV, `IDX_T1_RX_DIV, `IDX_MISC_CTL};
    {fails, tests_run} = '0;
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    void'($urandom(24214));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check(64'(clk_cfg), 64'h0);
    foreach (idx_tab[i]) begin
      rdreg(idx_tab[i], rd, rsp);
      check(64'(rd), 64'(exp_rd(idx_tab[i], 8'h00)));
    end
    for (int pass = 0; pass < 2; pass++) begin
      foreach (idx_tab[i]) begin
        v = (pass == 0) ? 8'($urandom) : 8'hFF;
        if (idx_tab[i] == `IDX_E1_CORR_HI) v = v & 8'h1F;
        if (idx_tab[i] == `IDX_MISC_CTL) v = v & 8'h03;
        if (idx_tab[i] == `IDX_E1_RX_DIV || idx_tab[i] == `IDX_T1_RX_DIV)
          v[6:4] = (pass == 1) ? 3'h5 : 3'($urandom_range(0, 5));
        wr(idx_tab[i], v, 1'b1, rsp);
        check(64'(rsp), 64'(`RESP_OKAY));
        rdreg(idx_tab[i], rd, rsp);
        check(64'(rd), 64'(exp_rd(idx_tab[i], v)));
      end
    end
    for (int c = 0; c < 8; c++) begin
      wr(`IDX_MISC_CTL, {6'h00, 2'(c)}, 1'b1, rsp);
      wr(`IDX_E1_CORR_HI, {3'h0, c[2], 4'h0}, 1'b1, rsp);
      settle();
      p0 = pulses;
      wr(`IDX_PLL_IN_DIV, 8'h01, 1'b1, rsp);
      wr(`IDX_PLL_FB_DIV, 8'h2F, 1'b1, rsp);
      wr(`IDX_PLL_IN_DIV, 8'h02, 1'b0, rsp);
      wr(`IDX_E1_RX_DIV, 8'h5B, 1'b1, rsp);
      settle();
      check(64'(pulses - p0), (c[2] && !c[1]) ? 64'h2 : 64'h0);
    end
    wr(`IDX_MISC_CTL, 8'h00, 1'b1, rsp);
    foreach (idx_tab[i]) begin
      v = (i < 4) ? 8'({8'h00, 8'h18, 8'hFB, 8'h0B} >> (8 * (3 - i)))
                  : 8'({8'h00, 8'h2F, 8'hDB, 8'hDF, 8'h00} >> (8 * (8 - i)));
      wr(idx_tab[i], v, 1'b1, rsp);
    end
    settle();
    check(64'(clk_cfg.pll_feedback_factor), 64'h2F);
    check(64'({clk_cfg.e1_rx_sixths,clk_cfg.e1_rx_integer}), 64'h5B);
    check(64'({clk_cfg.t1_rx_sixths,clk_cfg.t1_rx_integer}), 64'h5F);
    check(64'(clk_cfg.e1_freq_correction), 64'h800);
    check(64'(clk_cfg.t1_freq_correction), 64'hBFB);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'hFF : 8'($urandom);
      wr(`IDX_T1_CORR_LO, v, 1'b1, rsp);
      rdreg(`IDX_T1_CORR_LO, rd, rsp);
      settle();
      check(64'(rd), 64'(v));
      check(64'(clk_cfg.t1_freq_correction), 64'hBFB);
      wr(`IDX_T1_CORR_HI, 8'hA7, 1'b1, rsp);
      settle();
      check(64'(clk_cfg.t1_freq_correction), 64'({4'h7, v}));
      wr(`IDX_T1_CORR_HI, 8'h0B, 1'b1, rsp);
      wr(`IDX_T1_CORR_LO, 8'hFB, 1'b1, rsp);
      wr(`IDX_T1_CORR_HI, 8'h0B, 1'b1, rsp);
    end
    wr(`IDX_PLL_IN_DIV, 8'h81, 1'b1, rsp);
    settle();
    check(64'(clk_cfg.pll_input_factor), 64'h01);
    wr(`IDX_E1_CORR_HI, 8'h08, 1'b1, rsp);
    settle();
    check(64'({clk_cfg.flex_en,clk_cfg.pll_feedback_factor}), 64'h0);
    rdreg(`IDX_PLL_FB_DIV, rd, rsp);
    check(64'(rd), 64'h2F);
    // Fixed mode: phase, host and port bits still reach the datapath
    wr(`IDX_E1_CORR_HI, 8'hE8, 1'b1, rsp);
    wr(`IDX_MISC_CTL, 8'h0E, 1'b1, rsp);
    settle();
    // Slice is flex_en, host select, three phase bits, two port bits
    check(64'(clk_cfg[56:49]), 64'h5F);
    wr(10'h093, 8'h55, 1'b1, rsp);
    check(64'(rsp), 64'(`RESP_SLVERR));
    rdreg(10'h093, rd, rsp);
    check(64'({rsp, rd}), 64'({`RESP_SLVERR, 32'h0}));
    wr(`IDX_T1_CORR_LO, 8'h33, 1'b0, rsp);
    rdreg(`IDX_T1_CORR_LO, rd, rsp);
    check(64'({rsp, rd}), 64'({`RESP_OKAY, 32'hFB}));
    give_verdict();
  end
endmodule : tb_top

bind flexible_master_clock_pll_config flex_clock_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .clk_cfg, .pll_reset);
